// ==== inc/irq_halt_pkg.sv ====
// Constants shared by the interrupt and halt controller
`default_nettype none

package irq_halt_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam int PT_W = 2;
  localparam int KEY_W = 4;
  localparam int CT_W = 4;
  localparam int SW_W = 2;
  localparam int NUM_SRC = 7;

  // ==========================================================
  // Register map
  localparam logic [15:0] ADDR_EN_PTIMER = 16'hffe2;
  localparam logic [15:0] ADDR_EN_SERIAL = 16'hffe3;
  localparam logic [15:0] ADDR_EN_KEY0 = 16'hffe4;
  localparam logic [15:0] ADDR_EN_KEY1 = 16'hffe5;
  localparam logic [15:0] ADDR_EN_CTIMER = 16'hffe6;
  localparam logic [15:0] ADDR_EN_STOPWATCH = 16'hffe7;
  localparam logic [15:0] ADDR_PEND_PTIMER = 16'hfff2;
  localparam logic [15:0] ADDR_PEND_SERIAL = 16'hfff3;
  localparam logic [15:0] ADDR_PEND_KEY0 = 16'hfff4;
  localparam logic [15:0] ADDR_PEND_KEY1 = 16'hfff5;
  localparam logic [15:0] ADDR_PEND_CTIMER = 16'hfff6;
  localparam logic [15:0] ADDR_PEND_STOPWATCH = 16'hfff7;
  localparam logic [15:0] ADDR_KEY0_EDGE_SEL = 16'hffd0;
  localparam logic [15:0] ADDR_KEY1_EDGE_SEL = 16'hffd1;
  localparam logic [15:0] ADDR_STATUS = 16'hffd2;

  // ==========================================================
  // Reset values and status bit positions
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam int STAT_GLOBAL = 0;
  localparam int STAT_HALTED = 1;
  localparam int STAT_SP_OK = 2;

  // ==========================================================
  // Request order, highest priority first
  localparam int SRC_WDT = 0;
  localparam int SRC_PTIMER = 1;
  localparam int SRC_SERIAL = 2;
  localparam int SRC_KEY0 = 3;
  localparam int SRC_KEY1 = 4;
  localparam int SRC_CTIMER = 5;
  localparam int SRC_STOPWATCH = 6;

  // ==========================================================
  // Vector page and low program counter bits per source
  localparam logic [11:0] VEC_PAGE = 12'h010;
  localparam logic [3:0] VEC_LOW_TABLE [NUM_SRC] = '{
    4'h0, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he
  };

endpackage

`default_nettype wire

// ==== hdl/pin_edge_detect.sv ====
// Per-pin edge detector with rising or falling selection
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect #(
  parameter int W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pins_i,
  input wire logic [W-1:0] fall_sel_i,
  output logic [W-1:0] hit_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] prev;
    logic armed;
  } edge_state_t;

  edge_state_t q;
  edge_state_t d;

  always_comb begin
    d = q;
    d.prev = pins_i;
    d.armed = 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Edge per pin, suppressed until the first sample is held
  for (genvar i = 0; i < W; i++) begin : g_pin
    assign hit_o[i] = q.armed & (fall_sel_i[i] ? (q.prev[i] & ~pins_i[i])
                                               : (~q.prev[i] & pins_i[i]));
  end

endmodule

`default_nettype wire

// ==== hdl/vector_priority.sv ====
// Fixed-priority resolver giving the low vector bits
`timescale 1ns/1ps
`default_nettype none

module vector_priority (
  input wire logic [irq_halt_pkg::NUM_SRC-1:0] req_i,
  output logic any_o,
  output logic [3:0] vec_low_o
);

  // ==========================================================
  // Lowest priority first so the highest overwrites
  always_comb begin
    any_o = 1'b0;
    vec_low_o = irq_halt_pkg::NIBBLE_RESET;
    for (int i = irq_halt_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        vec_low_o = irq_halt_pkg::VEC_LOW_TABLE[i];
      end
    end
  end

endmodule

`default_nettype wire

// ==== hdl/irq_halt_ctrl.sv ====
// Interrupt and halt controller: flags, masks, priority, vector, wake
//
// Operation
// - Maskable request needs flag, mask, global on
// - Taking an interrupt clears global enable
// - Each timer channel sets flag at zero
// - Serial flag set on byte transfer done
// - Key group flag on selected pin edge
// - Clock timer taps falling edges set flags
// - Stopwatch 10 Hz and 1 Hz flags
// - Write one clears flag, zero keeps
// - Reset clears all pending flags
// - Mask bits read/write, zero blocks request
// - Reset clears all mask bits
// - Watchdog request ignores global enable, masks
// - Nothing taken until both stack pointers written
// - One stack pointer rewrite blocks until other
// - Take only at instruction boundary or out of halt
// - Entry: save flags, clear global, vector
// - Fixed vectors and priority, watchdog highest
// - Only four low vector bits supplied
// - Halt instruction enters halted state
// - Events still recorded while halted
// - Taken request releases halted state
`timescale 1ns/1ps
`default_nettype none

module irq_halt_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [3:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [3:0] reg_rdata_o,
  input wire logic [1:0] ptimer_zero_i,
  input wire logic serial_done_i,
  input wire logic [3:0] key_group0_pins_i,
  input wire logic [3:0] key_group1_pins_i,
  input wire logic [3:0] ctimer_taps_i,
  input wire logic stopwatch_10hz_i,
  input wire logic stopwatch_1hz_i,
  input wire logic watchdog_req_i,
  input wire logic insn_done_i,
  input wire logic halt_exec_i,
  input wire logic global_irq_on_i,
  input wire logic global_irq_off_i,
  input wire logic return_from_handler_i,
  input wire logic first_stack_pointer_wr_i,
  input wire logic second_stack_pointer_wr_i,
  output logic irq_request_o,
  output logic irq_entry_o,
  output logic [3:0] vector_low_o,
  output logic saved_global_o,
  output logic global_irq_o,
  output logic cpu_halted_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [irq_halt_pkg::PT_W-1:0] pend_pt;
    logic pend_si;
    logic pend_k0;
    logic pend_k1;
    logic [irq_halt_pkg::CT_W-1:0] pend_ct;
    logic [irq_halt_pkg::SW_W-1:0] pend_sw;
    logic [irq_halt_pkg::PT_W-1:0] en_pt;
    logic en_si;
    logic en_k0;
    logic en_k1;
    logic [irq_halt_pkg::CT_W-1:0] en_ct;
    logic [irq_halt_pkg::SW_W-1:0] en_sw;
    logic [irq_halt_pkg::KEY_W-1:0] ksel0;
    logic [irq_halt_pkg::KEY_W-1:0] ksel1;
    logic global_on;
    logic saved_global;
    logic sp_first;
    logic sp_second;
    logic halted;
    logic nmi;
    logic take;
    logic [3:0] vector;
    logic irq_req;
    logic [3:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  logic [3:0] key0_hit;
  logic [3:0] key1_hit;
  logic [3:0] ct_hit;
  logic [irq_halt_pkg::NUM_SRC-1:0] req;
  logic req_any;
  logic [3:0] req_vec;
  logic sp_ok;

  function automatic logic hit(input logic [15:0] off);
    hit = (reg_addr_i == off);
  endfunction

  // ==========================================================
  // Event edge detection
  pin_edge_detect #(.W(irq_halt_pkg::KEY_W)) u_key0 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(key_group0_pins_i),
    .fall_sel_i(q.ksel0),
    .hit_o(key0_hit)
  );

  pin_edge_detect #(.W(irq_halt_pkg::KEY_W)) u_key1 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(key_group1_pins_i),
    .fall_sel_i(q.ksel1),
    .hit_o(key1_hit)
  );

  pin_edge_detect #(.W(irq_halt_pkg::CT_W)) u_ctimer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(ctimer_taps_i),
    .fall_sel_i({irq_halt_pkg::CT_W{1'b1}}),
    .hit_o(ct_hit)
  );

  // ==========================================================
  // Request gating and priority
  always_comb begin
    sp_ok = q.sp_first & q.sp_second;
    req = '0;
    req[irq_halt_pkg::SRC_WDT] = q.nmi;
    req[irq_halt_pkg::SRC_PTIMER] = |(q.pend_pt & q.en_pt);
    req[irq_halt_pkg::SRC_SERIAL] = q.pend_si & q.en_si;
    req[irq_halt_pkg::SRC_KEY0] = q.pend_k0 & q.en_k0;
    req[irq_halt_pkg::SRC_KEY1] = q.pend_k1 & q.en_k1;
    req[irq_halt_pkg::SRC_CTIMER] = |(q.pend_ct & q.en_ct);
    req[irq_halt_pkg::SRC_STOPWATCH] = |(q.pend_sw & q.en_sw);
    for (int i = irq_halt_pkg::SRC_PTIMER; i < irq_halt_pkg::NUM_SRC; i++) begin
      req[i] = req[i] & q.global_on;
    end
    if (!sp_ok) begin
      req = '0;
    end
  end

  vector_priority u_prio (
    .req_i(req),
    .any_o(req_any),
    .vec_low_o(req_vec)
  );

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.take = 1'b0;
    d.rdata = irq_halt_pkg::NIBBLE_RESET;
    d.irq_req = req_any;

    // Write one to clear, hardware set wins, recorded even when halted
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_PEND_PTIMER)) begin
      d.pend_pt = q.pend_pt & ~reg_wdata_i[irq_halt_pkg::PT_W-1:0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_PEND_SERIAL)) begin
      d.pend_si = q.pend_si & ~reg_wdata_i[0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_PEND_KEY0)) begin
      d.pend_k0 = q.pend_k0 & ~reg_wdata_i[0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_PEND_KEY1)) begin
      d.pend_k1 = q.pend_k1 & ~reg_wdata_i[0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_PEND_CTIMER)) begin
      d.pend_ct = q.pend_ct & ~reg_wdata_i;
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_PEND_STOPWATCH)) begin
      d.pend_sw = q.pend_sw & ~reg_wdata_i[irq_halt_pkg::SW_W-1:0];
    end
    d.pend_pt = d.pend_pt | ptimer_zero_i;
    d.pend_si = d.pend_si | serial_done_i;
    d.pend_k0 = d.pend_k0 | (|key0_hit);
    d.pend_k1 = d.pend_k1 | (|key1_hit);
    d.pend_ct = d.pend_ct | ct_hit;
    d.pend_sw = d.pend_sw | {stopwatch_1hz_i, stopwatch_10hz_i};

    // Mask and edge select writes
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_EN_PTIMER)) begin
      d.en_pt = reg_wdata_i[irq_halt_pkg::PT_W-1:0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_EN_SERIAL)) begin
      d.en_si = reg_wdata_i[0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_EN_KEY0)) begin
      d.en_k0 = reg_wdata_i[0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_EN_KEY1)) begin
      d.en_k1 = reg_wdata_i[0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_EN_CTIMER)) begin
      d.en_ct = reg_wdata_i;
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_EN_STOPWATCH)) begin
      d.en_sw = reg_wdata_i[irq_halt_pkg::SW_W-1:0];
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_KEY0_EDGE_SEL)) begin
      d.ksel0 = reg_wdata_i;
    end
    if (reg_wr_i && hit(irq_halt_pkg::ADDR_KEY1_EDGE_SEL)) begin
      d.ksel1 = reg_wdata_i;
    end

    // Read data, one cycle after the strobe only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        irq_halt_pkg::ADDR_EN_PTIMER: d.rdata = {2'b00, q.en_pt};
        irq_halt_pkg::ADDR_EN_SERIAL: d.rdata = {3'b000, q.en_si};
        irq_halt_pkg::ADDR_EN_KEY0: d.rdata = {3'b000, q.en_k0};
        irq_halt_pkg::ADDR_EN_KEY1: d.rdata = {3'b000, q.en_k1};
        irq_halt_pkg::ADDR_EN_CTIMER: d.rdata = q.en_ct;
        irq_halt_pkg::ADDR_EN_STOPWATCH: d.rdata = {2'b00, q.en_sw};
        irq_halt_pkg::ADDR_PEND_PTIMER: d.rdata = {2'b00, q.pend_pt};
        irq_halt_pkg::ADDR_PEND_SERIAL: d.rdata = {3'b000, q.pend_si};
        irq_halt_pkg::ADDR_PEND_KEY0: d.rdata = {3'b000, q.pend_k0};
        irq_halt_pkg::ADDR_PEND_KEY1: d.rdata = {3'b000, q.pend_k1};
        irq_halt_pkg::ADDR_PEND_CTIMER: d.rdata = q.pend_ct;
        irq_halt_pkg::ADDR_PEND_STOPWATCH: d.rdata = {2'b00, q.pend_sw};
        irq_halt_pkg::ADDR_KEY0_EDGE_SEL: d.rdata = q.ksel0;
        irq_halt_pkg::ADDR_KEY1_EDGE_SEL: d.rdata = q.ksel1;
        irq_halt_pkg::ADDR_STATUS: begin
          d.rdata[irq_halt_pkg::STAT_GLOBAL] = q.global_on;
          d.rdata[irq_halt_pkg::STAT_HALTED] = q.halted;
          d.rdata[irq_halt_pkg::STAT_SP_OK] = sp_ok;
        end
        default: d.rdata = irq_halt_pkg::NIBBLE_RESET;
      endcase
    end

    // Stack pointer pairing
    if (first_stack_pointer_wr_i) begin
      d.sp_first = 1'b1;
      if (q.sp_first && q.sp_second && !second_stack_pointer_wr_i) begin
        d.sp_second = 1'b0;
      end
    end
    if (second_stack_pointer_wr_i) begin
      d.sp_second = 1'b1;
      if (q.sp_first && q.sp_second && !first_stack_pointer_wr_i) begin
        d.sp_first = 1'b0;
      end
    end

    // Global flag and halt from the CPU
    if (global_irq_on_i) begin
      d.global_on = 1'b1;
    end
    if (global_irq_off_i) begin
      d.global_on = 1'b0;
    end
    if (return_from_handler_i) begin
      d.global_on = q.saved_global;
    end
    if (halt_exec_i) begin
      d.halted = 1'b1;
    end

    // Entry at an instruction boundary or out of halt
    if (req_any && (insn_done_i || q.halted)) begin
      d.take = 1'b1;
      d.saved_global = q.global_on;
      d.global_on = 1'b0;
      d.vector = req_vec;
      d.halted = 1'b0;
      if (req_vec == irq_halt_pkg::VEC_LOW_TABLE[irq_halt_pkg::SRC_WDT]) begin
        d.nmi = 1'b0;
      end
    end
    if (watchdog_req_i) begin
      d.nmi = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = q.rdata;
  assign irq_request_o = q.irq_req;
  assign irq_entry_o = q.take;
  assign vector_low_o = q.vector;
  assign saved_global_o = q.saved_global;
  assign global_irq_o = q.global_on;
  assign cpu_halted_o = q.halted;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_SP_PAIR_NEEDED: assert property (
    q.take |-> $past(q.sp_first && q.sp_second)
  ) else $error("interrupt taken without both stack pointers");

  AST_GLOBAL_CLEARED: assert property (
    q.take |-> !q.global_on && q.saved_global == $past(q.global_on)
  ) else $error("global enable not cleared on entry");

  AST_MASKABLE_NEEDS_GLOBAL: assert property (
    (q.take && q.vector != irq_halt_pkg::VEC_LOW_TABLE[irq_halt_pkg::SRC_WDT])
      |-> $past(q.global_on)
  ) else $error("maskable interrupt taken with global off");

  AST_W1C_SERIAL: assert property (
    (reg_wr_i && reg_addr_i == irq_halt_pkg::ADDR_PEND_SERIAL && reg_wdata_i[0]
      && !serial_done_i) |=> !q.pend_si
  ) else $error("serial flag not cleared by write of one");

  AST_SET_WINS: assert property (
    serial_done_i |=> q.pend_si
  ) else $error("serial event lost");

  AST_WAKE: assert property (
    (q.halted && req_any) |=> !q.halted && q.take
  ) else $error("halt not released by taken request");

  AST_CTIMER_FALL: assert property (
    (ct_hit[0] && !(reg_wr_i && reg_addr_i == irq_halt_pkg::ADDR_PEND_CTIMER)) ##1 1'b1
      [*2] |-> $past(q.pend_ct[0])
  ) else $error("clock timer flag missed");

  AST_EN_READBACK: assert property (
    $past(reg_rd_i && reg_addr_i == irq_halt_pkg::ADDR_EN_STOPWATCH)
      |-> reg_rdata_o == {2'b00, $past(q.en_sw)}
  ) else $error("mask readback wrong");

  AST_NMI_FIRST: assert property (
    (q.nmi && req_any && insn_done_i) |=> q.take
      && q.vector == irq_halt_pkg::VEC_LOW_TABLE[irq_halt_pkg::SRC_WDT]
  ) else $error("watchdog not highest priority");

  AST_BOUNDARY: assert property (
    q.take |-> $past(insn_done_i || q.halted)
  ) else $error("interrupt taken mid instruction");

  COV_NMI: cover property (q.take
    && q.vector == irq_halt_pkg::VEC_LOW_TABLE[irq_halt_pkg::SRC_WDT]);
  COV_WAKE: cover property (q.halted ##1 q.take);
  COV_KEY: cover property ((|key0_hit) ##[1:20] q.take);

endmodule

`default_nettype wire

// ==== dv/cpu_core_model.sv ====
// CPU core partner model: instruction boundaries and stack pointer writes
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic cpu_halted_i,
  input wire logic [1:0] sp_req_i,
  output logic insn_done_o,
  output logic first_sp_wr_o,
  output logic second_sp_wr_o
);
  logic [1:0] cnt_q;

  // ==========================================================
  // Instruction boundaries, every cycle or every fourth, none while stopped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      insn_done_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      insn_done_o <= !cpu_halted_i && (!slow_i || cnt_q == 2'h3);
    end
  end

  // ==========================================================
  // Stack pointer writes; the bench asks for each half of the pair
  always_ff @(posedge core_clk_i) begin
    first_sp_wr_o <= !rst_i && sp_req_i[0];
    second_sp_wr_o <= !rst_i && sp_req_i[1];
  end
endmodule
`default_nettype wire

// ==== dv/irq_halt_ctrl_tb_top.sv ====
// Self-checking testbench for the interrupt and halt controller
`timescale 1ns/1ps
`default_nettype none

module irq_halt_ctrl_tb_top;
  localparam logic [9:0] PT0 = 10'h001;
  localparam logic [9:0] PT1 = 10'h002;
  localparam logic [9:0] SER = 10'h004;
  localparam logic [9:0] SW10 = 10'h008;
  localparam logic [9:0] SW1 = 10'h010;
  localparam logic [9:0] WDT = 10'h020;
  localparam logic [9:0] HALT = 10'h040;
  localparam logic [9:0] GON = 10'h080;
  localparam logic [9:0] GOFF = 10'h100;
  localparam logic [9:0] RET = 10'h200;
  logic clk, rst, wr, rd, slow, idone, sp1, sp2, req, entry, sglob, glob, halted;
  logic done_q, halt_q;
  logic [15:0] addr;
  logic [3:0] wdata, rdata, vec, k0, k1, taps;
  logic [9:0] p;
  logic [1:0] spq;
  int errors;
  int n_checks;
  logic [3:0] msk [6] = '{4'h3, 4'h1, 4'h1, 4'h1, 4'hf, 4'h3};
  logic [3:0] pexp [6] = '{4'h2, 4'h1, 4'h1, 4'h1, 4'h9, 4'h2};
  logic [3:0] vexp [6] = '{4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};

  // ==========================================================
  // Design and partner
  irq_halt_ctrl irq_halt_ctrl_inst (
    .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ptimer_zero_i(p[1:0]),
    .serial_done_i(p[2]), .key_group0_pins_i(k0), .key_group1_pins_i(k1),
    .ctimer_taps_i(taps), .stopwatch_10hz_i(p[3]), .stopwatch_1hz_i(p[4]),
    .watchdog_req_i(p[5]), .insn_done_i(idone), .halt_exec_i(p[6]),
    .global_irq_on_i(p[7]), .global_irq_off_i(p[8]), .return_from_handler_i(p[9]),
    .first_stack_pointer_wr_i(sp1), .second_stack_pointer_wr_i(sp2),
    .irq_request_o(req), .irq_entry_o(entry), .vector_low_o(vec),
    .saved_global_o(sglob), .global_irq_o(glob), .cpu_halted_o(halted)
  );
  cpu_core_model cpu_core_model_inst (
    .core_clk_i(clk), .rst_i(rst), .slow_i(slow), .cpu_halted_i(halted),
    .sp_req_i(spq), .insn_done_o(idone), .first_sp_wr_o(sp1), .second_sp_wr_o(sp2)
  );

  // ==========================================================
  // Clock, verdict, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    print_verdict();
  end

  // ==========================================================
  // Access and compare tasks
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [3:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  task automatic pulse(input logic [9:0] m);
    @(posedge clk);
    p <= m;
    @(posedge clk);
    p <= '0;
  endtask

  task automatic sp(input logic [1:0] m);
    @(posedge clk);
    spq <= m;
    @(posedge clk);
    spq <= 2'b00;
  endtask

  task automatic ent(input logic [3:0] v);
    int i;
    i = 0;
    @(negedge clk);
    while (entry !== 1'b1 && i < 40) begin
      @(negedge clk);
      i++;
    end
    chk({3'b000, entry}, 4'h1);
    chk({3'b000, req}, 4'h1);
    chk(vec, v);
    chk({3'b000, glob}, 4'h0);
  endtask

  task automatic none(input int n);
    repeat (n) begin
      @(negedge clk);
      chk({3'b000, entry}, 4'h0);
    end
  endtask

  // Entry only at an instruction boundary or from the halted state
  always @(posedge clk) begin
    done_q <= idone;
    halt_q <= halted;
    if (!rst && entry === 1'b1) chk({3'b000, done_q | halt_q}, 4'h1);
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {wr, rd, slow} = '0;
    addr = '0;
    wdata = '0;
    p = '0;
    spq = '0;
    k0 = 4'h0;
    k1 = 4'h0;
    taps = 4'hf;
    errors = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rchk(16'hffe2 + 16'(i), 4'h0);
      rchk(16'hfff2 + 16'(i), 4'h0);
      wreg(16'hffe2 + 16'(i), 4'hf);
      rchk(16'hffe2 + 16'(i), msk[i]);
    end
    rchk(16'hff00, 4'h0);
    // Nothing taken before both stack pointers
    pulse(GON);
    pulse(SER);
    pulse(WDT);
    none(10);
    rchk(16'hfff3, 4'h1);
    sp(2'b01);
    none(10);
    sp(2'b10);
    ent(4'h0);
    chk({3'b000, sglob}, 4'h1);
    rchk(16'hffd2, 4'h4);
    none(10);
    chk({3'b000, req}, 4'h0);
    wreg(16'hfff3, 4'h1);
    rchk(16'hfff3, 4'h0);
    pulse(WDT);
    ent(4'h0);
    // All six maskable sources at once, slow instruction boundaries
    @(posedge clk);
    slow <= 1'b1;
    k0 <= 4'h1;
    k1 <= 4'h8;
    taps <= 4'h6;
    p <= PT1 | SER | SW1;
    @(posedge clk);
    p <= '0;
    for (int i = 0; i < 6; i++) rchk(16'hfff2 + 16'(i), pexp[i]);
    pulse(GON);
    for (int i = 0; i < 6; i++) begin
      ent(vexp[i]);
      wreg(16'hfff2 + 16'(i), 4'hf);
      pulse(RET);
    end
    none(10);
    // Masked source still records its flag
    wreg(16'hffe7, 4'h0);
    pulse(SW10);
    none(10);
    wreg(16'hfff7, 4'h0);
    chk({3'b000, req}, 4'h0);
    rchk(16'hfff7, 4'h1);
    wreg(16'hffe7, 4'h3);
    ent(4'he);
    wreg(16'hfff7, 4'hf);
    // Event and clear in one cycle
    pulse(GOFF);
    @(posedge clk);
    p <= SER;
    wr <= 1'b1;
    addr <= 16'hfff3;
    wdata <= 4'h1;
    @(posedge clk);
    p <= '0;
    wr <= 1'b0;
    rchk(16'hfff3, 4'h1);
    none(10);
    wreg(16'hfff3, 4'h1);
    // Falling edge selected on key group 0
    wreg(16'hffd0, 4'h1);
    rchk(16'hffd0, 4'h1);
    @(posedge clk);
    k0 <= 4'h0;
    rchk(16'hfff4, 4'h1);
    wreg(16'hfff4, 4'h1);
    // Halt and wake
    @(posedge clk);
    slow <= 1'b0;
    pulse(GON);
    pulse(HALT);
    none(10);
    chk({3'b000, halted}, 4'h1);
    rchk(16'hffd2, 4'h7);
    pulse(PT0);
    ent(4'h4);
    chk({3'b000, halted}, 4'h0);
    rchk(16'hfff2, 4'h1);
    wreg(16'hfff2, 4'h1);
    // One stack pointer rewritten
    sp(2'b01);
    pulse(WDT);
    none(10);
    sp(2'b10);
    ent(4'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
